//--- hdl/iopau_pkg.sv
// Purpose: shared constants of the i/o port access unit and its decoder end
// Assumes: 32-bit data path, four byte lanes, 16-bit i/o port numbers
// Notes: command encoding is shared by both ends of the bus
package iopau_pkg;
    // ************************************************************
    // transfer sizes and lanes
    // ************************************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_DWORD = 2'h2;
    localparam int LANES = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] MASK_BYTE = 4'h1;
    localparam logic [3:0] MASK_WORD = 4'h3;
    localparam logic [3:0] MASK_DWORD = 4'hf;
    // ************************************************************
    // i/o address space
    // ************************************************************
    localparam int IO_ADDR_W = 16;
    localparam logic [15:0] IO_PORT_MAX = 16'hffff;
    localparam logic [15:0] IO_RSVD_LO = 16'h00f8;
    localparam logic [15:0] IO_RSVD_HI = 16'h00ff;
    // ************************************************************
    // request command lines of the newer bus: bit 1 i/o, bit 0 write
    // ************************************************************
    localparam logic [1:0] CMD_MEM_RD = 2'h0;
    localparam logic [1:0] CMD_MEM_WR = 2'h1;
    localparam logic [1:0] CMD_IO_RD = 2'h2;
    localparam logic [1:0] CMD_IO_WR = 2'h3;
    localparam int CMD_IO_BIT = 1;
    // memory/io select level of the older bus
    localparam logic SEL_MEM = 1'b1;
    localparam logic SEL_IO = 1'b0;
endpackage : iopau_pkg

//--- hdl/iopau_if.sv
// Purpose: processor bus between the port access unit and the external decoder
// Assumes: one clock, both ends on sys_clk
// Notes: request held until the one-cycle ready
`timescale 1ns/10ps
`default_nettype none
interface iopau_if;
    logic busReq;
    logic [31:0] busAddr;
    logic [3:0] busByteEn;
    logic busMemIo;
    logic [1:0] busCmd;
    logic [31:0] busWdata;
    logic [31:0] busRdata;
    logic busReady;
    logic busParityErr;
    logic cacheEnableIn_n;
    // processor end
    modport devEnd (output busReq, busAddr, busByteEn, busMemIo, busCmd, busWdata,
                    input busRdata, busReady, busParityErr, cacheEnableIn_n);
    // decoder and ports end
    modport hostEnd (input busReq, busAddr, busByteEn, busMemIo, busCmd, busWdata,
                     output busRdata, busReady, busParityErr, cacheEnableIn_n);
endinterface : iopau_if
`default_nettype wire

//--- hdl/iopau_decoder.sv
// Purpose: external decoder: steers bus cycles to i/o ports or memory
// Assumes: ports answer combinationally in the strobe cycle
// Notes: reserved ports are acknowledged but never selected
`timescale 1ns/10ps
`default_nettype none
module iopau_decoder #(
    parameter bit NEW_BUS = 1'b1,
    parameter logic [31:0] UNC_BASE = 32'h000a_0000,
    parameter logic [31:0] UNC_LIMIT = 32'h000f_ffff
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    iopau_if.hostEnd bus,
    output logic portStrobe,
    output logic memStrobe,
    output logic reservedHit,
    output logic accWrite,
    output logic [31:0] accAddr,
    output logic [3:0] accByteEn,
    output logic [31:0] accWdata,
    input wire logic [31:0] portRdata,
    input wire logic [31:0] memRdata,
    input wire logic parityErrIn
);
    import iopau_pkg::*;

    logic cycIsIo;
    logic launch;
    logic strobeReg;
    logic ioReg;
    logic rsvdNow;

    generate
        if (UNC_BASE > UNC_LIMIT) begin : g_bad_range
            $error("uncached range base above limit");
        end
    endgenerate

    // ************************************************************
    // decode of each bus cycle
    // ************************************************************
    // memory or i/o from whichever bus variant is in use
    assign cycIsIo = NEW_BUS ? bus.busCmd[CMD_IO_BIT] : (bus.busMemIo == SEL_IO);
    assign launch = bus.busReq & ~strobeReg;
    assign rsvdNow = cycIsIo && (bus.busAddr[15:0] >= IO_RSVD_LO) && (bus.busAddr[15:0] <= IO_RSVD_HI);

    // capture the cycle; strobe stands one cycle, ready rides with it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            strobeReg <= 1'b0;
            ioReg <= 1'b0;
            portStrobe <= 1'b0;
            memStrobe <= 1'b0;
            reservedHit <= 1'b0;
            accWrite <= 1'b0;
            accAddr <= 32'h0000_0000;
            accByteEn <= 4'h0;
            accWdata <= 32'h0000_0000;
        end else if (clkEn) begin
            strobeReg <= launch;
            if (launch) begin
                ioReg <= cycIsIo;
                portStrobe <= cycIsIo & ~rsvdNow;
                memStrobe <= ~cycIsIo;
                reservedHit <= rsvdNow;
                accWrite <= NEW_BUS ? bus.busCmd[0] : 1'b0;
                accAddr <= bus.busAddr;
                accByteEn <= bus.busByteEn;
                accWdata <= bus.busWdata;
            end else begin
                portStrobe <= 1'b0;
                memStrobe <= 1'b0;
                reservedHit <= 1'b0;
            end
        end
    end

    // answer in the strobe cycle; reserved ports read as zero
    assign bus.busReady = strobeReg & clkEn;
    assign bus.busRdata = !strobeReg ? 32'h0000_0000 : reservedHit ? 32'h0000_0000 : ioReg ? portRdata : memRdata;
    assign bus.busParityErr = strobeReg & parityErrIn;
    // block caching for i/o and the uncached memory window
    assign bus.cacheEnableIn_n = cycIsIo | ((bus.busAddr >= UNC_BASE) && (bus.busAddr <= UNC_LIMIT));
endmodule : iopau_decoder
`default_nettype wire

//--- hdl/iopau_device.sv
// Purpose: processor side port access unit: turns core accesses into bus cycles
// Assumes: core holds a request until taken and waits for the response
// Notes: older bus write direction travels only on the command lines;
//        on the older variant the decoder ties its write flag accWrite low
//
// Overview of operation
// - separate 64K byte i/o space, ports 0..FFFFH
// - no ports at 0F8H..0FFH
// - older bus: select high memory, low i/o
// - newer bus: command lines mark memory or i/o
// - decoder selects ports on i/o cycles
// - port data on data lines, number on address
// - 8, 16, 32 bit transfers over byte ports
// - aligned wide accesses take one bus cycle
// - unaligned accesses take extra bus cycles
// - order of split cycles is not guaranteed
// - i/o write completes before next instruction
// - parity errors on i/o never masked
// - memory instructions reach memory mapped ports
// - memory mapped i/o kept uncached
// - older bus: inactive cache enable blocks caching
// - decoder drives cache enable inactive where needed
// - page cache disable flag blocks caching
`timescale 1ns/10ps
`default_nettype none
module iopau_device #(
    parameter bit NEW_BUS = 1'b1,
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqIsIo,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [1:0] reqSize,
    input wire logic [31:0] reqWdata,
    input wire logic reqPageCacheDisable,
    input wire logic reqUncacheableType,
    input wire logic parityMaskEn,
    output logic rspValid,
    output logic [31:0] rspRdata,
    output logic rspParityErr,
    output logic rspCacheable,
    iopau_if.devEnd bus
);
    import iopau_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUS = 3'b010,
        ST_DONE = 3'b100
    } iopau_state_e;

    iopau_state_e state_reg;
    iopau_state_e state_next;
    logic [ADDR_W-1:0] addr_reg;
    logic isIo_reg;
    logic write_reg;
    logic [1:0] size_reg;
    logic unaligned_reg;
    logic [1:0] idx_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic parity_reg;
    logic cache_reg;
    logic [1:0] lane;
    logic [1:0] lastIdx;
    logic [3:0] sizeMask;
    logic reqAligned;
    logic take;
    logic lastCycle;
    logic [31:0] laneShifted;
    logic [31:0] rdShifted;

    // ************************************************************
    // parameter checks
    // ************************************************************
    generate
        if (ADDR_W < IO_ADDR_W + 1 || ADDR_W > 32) begin : g_bad_addr
            $error("address width must lie between 17 and 32");
        end
    endgenerate

    // ************************************************************
    // request decode
    // ************************************************************
    // size to lane mask; a wide port is consecutive byte ports
    always_comb begin
        case (size_reg)
            SIZE_BYTE: sizeMask = MASK_BYTE;
            SIZE_WORD: sizeMask = MASK_WORD;
            default: sizeMask = MASK_DWORD;
        endcase
    end

    // natural alignment of the incoming request
    always_comb begin
        case (reqSize)
            SIZE_BYTE: reqAligned = 1'b1;
            SIZE_WORD: reqAligned = ~reqAddr[0];
            default: reqAligned = (reqAddr[1:0] == 2'h0);
        endcase
    end

    assign take = reqValid & reqReady;
    assign reqReady = (state_reg == ST_IDLE) & clkEn;
    assign lane = addr_reg[1:0];
    assign lastIdx = 2'((1 << size_reg) - 1);
    // aligned cycles finish at once; split ones after the last byte
    assign lastCycle = ~unaligned_reg | (idx_reg == lastIdx);

    // ************************************************************
    // state machine
    // ************************************************************
    // response waits for the last bus ready, so an i/o write is done
    // before the core may issue its next instruction
    always_comb begin
        case (state_reg)
            ST_IDLE: state_next = take ? ST_BUS : ST_IDLE;
            ST_BUS: state_next = (bus.busReady && lastCycle) ? ST_DONE : ST_BUS;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // transfer bookkeeping
    // ************************************************************
    // split cycles go low byte first; callers must not count on that
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_reg <= '0;
            isIo_reg <= 1'b0;
            write_reg <= 1'b0;
            size_reg <= SIZE_BYTE;
            unaligned_reg <= 1'b0;
            idx_reg <= 2'h0;
            wdata_reg <= 32'h0000_0000;
        end else if (clkEn) begin
            if (take) begin
                // i/o port numbers wrap inside the 64K space
                addr_reg <= reqIsIo ? ADDR_W'(reqAddr[IO_ADDR_W-1:0]) : reqAddr;
                isIo_reg <= reqIsIo;
                write_reg <= reqWrite;
                size_reg <= reqSize;
                unaligned_reg <= ~reqAligned;
                idx_reg <= 2'h0;
                wdata_reg <= reqWdata;
            end else if (state_reg == ST_BUS && bus.busReady && !lastCycle) begin
                idx_reg <= idx_reg + 2'h1;
                addr_reg <= isIo_reg ? ADDR_W'(16'(addr_reg[IO_ADDR_W-1:0] + 16'h0001)) : addr_reg + ADDR_W'(1);
            end
        end
    end

    // ************************************************************
    // read data, parity and cacheability collection
    // ************************************************************
    assign rdShifted = bus.busRdata >> {lane, 3'b000};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0000_0000;
            parity_reg <= 1'b0;
            cache_reg <= 1'b0;
        end else if (clkEn) begin
            if (take) begin
                rdata_reg <= 32'h0000_0000;
                parity_reg <= 1'b0;
                // i/o is never cached; page flag, or range type on the newer bus, blocks memory
                cache_reg <= ~reqIsIo & ~reqPageCacheDisable & (~NEW_BUS | ~reqUncacheableType);
            end else if (state_reg == ST_BUS && bus.busReady) begin
                if (unaligned_reg) begin
                    rdata_reg[idx_reg*8 +: 8] <= rdShifted[7:0];
                end else begin
                    rdata_reg <= rdShifted & {{8{sizeMask[3]}}, {8{sizeMask[2]}}, {8{sizeMask[1]}}, {8{sizeMask[0]}}};
                end
                // the mask enable covers memory cycles only
                parity_reg <= parity_reg | (bus.busParityErr & (isIo_reg | ~parityMaskEn));
                if (!NEW_BUS && bus.cacheEnableIn_n) begin
                    cache_reg <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // bus drive
    // ************************************************************
    // size mask shifted to the byte offset; split cycles carry a single lane
    assign bus.busByteEn = (state_reg != ST_BUS) ? 4'h0 :
        unaligned_reg ? 4'(MASK_BYTE << lane) : 4'(sizeMask << lane);
    assign bus.busReq = (state_reg == ST_BUS);
    // port number on the address lines, dword aligned with byte enables
    assign bus.busAddr = 32'({addr_reg[ADDR_W-1:2], 2'b00});
    assign bus.busMemIo = NEW_BUS ? SEL_MEM : (isIo_reg ? SEL_IO : SEL_MEM);
    always_comb begin
        case ({isIo_reg, write_reg})
            2'b00: bus.busCmd = CMD_MEM_RD;
            2'b01: bus.busCmd = CMD_MEM_WR;
            2'b10: bus.busCmd = CMD_IO_RD;
            default: bus.busCmd = CMD_IO_WR;
        endcase
    end
    // replicating the byte lets the enables pick the lane
    assign laneShifted = wdata_reg << {lane, 3'b000};
    assign bus.busWdata = unaligned_reg ? {LANES{wdata_reg[idx_reg*8 +: 8]}} : laneShifted;

    // ************************************************************
    // response
    // ************************************************************
    assign rspValid = (state_reg == ST_DONE);
    assign rspRdata = rdata_reg;
    assign rspParityErr = parity_reg;
    assign rspCacheable = cache_reg;
endmodule : iopau_device
`default_nettype wire

//--- verif/iopau_monitor.sv
// Purpose: bus checker between the port access unit and its decoder
// Assumes: newer bus variant, clkEn held high by the bench
// Notes: watches interface signals only, instantiated beside the interface
`timescale 1ns/10ps
`default_nettype none
module iopau_monitor
    import iopau_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic busReq,
    input wire logic [31:0] busAddr,
    input wire logic [3:0] busByteEn,
    input wire logic busMemIo,
    input wire logic [1:0] busCmd,
    input wire logic [31:0] busRdata,
    input wire logic busReady,
    input wire logic cacheEnableIn_n
);
    // ************************************************************
    // bus cycle assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // a pending cycle keeps address and lanes until its ready
    req_hold_a: assert property (busReq && !busReady |=> busReq && $stable(busAddr) && $stable(busByteEn))
        else $error("bus request dropped or changed before ready");
    // decoder answers one cycle after launch
    ready_time_a: assert property (busReq && !busReady |=> busReady)
        else $error("ready not one cycle after launch");
    no_stray_a: assert property (!busReq |-> !busReady)
        else $error("ready without a request");
    io_range_a: assert property (busReq && busCmd[CMD_IO_BIT] |-> busAddr[31:16] == 16'h0)
        else $error("i/o port number beyond 16 bits");
    dword_addr_a: assert property (busReq |-> busAddr[1:0] == 2'h0)
        else $error("bus address not dword aligned");
    newbus_sel_a: assert property (busReq |-> busMemIo == SEL_MEM)
        else $error("select line moved on newer bus");
    lane_set_a: assert property (busReq |-> busByteEn inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
        else $error("illegal byte lane pattern");
    io_uncached_a: assert property (busReady && busCmd[CMD_IO_BIT] |-> cacheEnableIn_n)
        else $error("i/o cycle marked cacheable");
    rsvd_zero_a: assert property (busReady && busCmd == CMD_IO_RD && busAddr[15:3] == 13'h1f |-> busRdata == 32'h0)
        else $error("reserved port returned data");
endmodule : iopau_monitor
`default_nettype wire

//--- verif/iopau_bench.sv
// Purpose: self-checking bench joining the access unit and the decoder
// Assumes: newer bus, clkEn tied high, 25 MHz clock
// Notes: split cycle order is never checked, only their union
`timescale 1ns/10ps
`default_nettype none
`define CHK(name, exp, got) begin nTests++; if ((got) !== (exp)) begin errCount++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); end end
module iopau_bench;
    import iopau_pkg::*;
    logic sys_clk, arst_n, reqValid, reqReady, reqIsIo, reqWrite, reqPcd, reqUnc, parityMaskEn, parityErrIn;
    logic rspValid, rspParityErr, rspCacheable, portStrobe, memStrobe, reservedHit, accWrite;
    logic [1:0] reqSize;
    logic [3:0] accByteEn, laneOr;
    logic [31:0] reqAddr, reqWdata, rspRdata, accAddr, accWdata, addrOr;
    int errCount, nTests, lat, portCnt, memCnt, rsvdCnt, cycles;
    iopau_if bus();
    iopau_device u_iopau_device (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(1'b1), .reqValid(reqValid),
        .reqReady(reqReady), .reqIsIo(reqIsIo), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqSize(reqSize),
        .reqWdata(reqWdata), .reqPageCacheDisable(reqPcd), .reqUncacheableType(reqUnc),
        .parityMaskEn(parityMaskEn), .rspValid(rspValid), .rspRdata(rspRdata), .rspParityErr(rspParityErr),
        .rspCacheable(rspCacheable), .bus(bus));
    iopau_decoder u_iopau_decoder (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(1'b1), .bus(bus),
        .portStrobe(portStrobe), .memStrobe(memStrobe), .reservedHit(reservedHit), .accWrite(accWrite),
        .accAddr(accAddr), .accByteEn(accByteEn), .accWdata(accWdata), .portRdata(32'h1122_3344),
        .memRdata(32'h5566_7788), .parityErrIn(parityErrIn));
    iopau_monitor u_iopau_monitor (.sys_clk(sys_clk), .arst_n(arst_n), .busReq(bus.busReq),
        .busAddr(bus.busAddr), .busByteEn(bus.busByteEn), .busMemIo(bus.busMemIo), .busCmd(bus.busCmd),
        .busRdata(bus.busRdata), .busReady(bus.busReady), .cacheEnableIn_n(bus.cacheEnableIn_n));
    // ************************************************************
    // clock, timeout and strobe bookkeeping
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // union of split cycles, so the check does not lean on their order
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 2000) begin
            errCount++;
            end_of_test();
        end
        if (portStrobe === 1'b1) begin
            portCnt++;
            laneOr = laneOr | accByteEn;
            addrOr = addrOr | accAddr;
        end
        if (memStrobe === 1'b1) memCnt++;
        if (reservedHit === 1'b1) rsvdCnt++;
    end
    // one core request, latency counted from the take edge
    task automatic req(input logic io, input logic wr, input logic [31:0] a, input logic [1:0] sz,
                       input logic [31:0] wd, input logic page_cache_disable, input logic unc);
        @(negedge sys_clk);
        {portCnt, memCnt, rsvdCnt, laneOr, addrOr} = '0;
        {reqValid, reqIsIo, reqWrite, reqAddr, reqSize, reqWdata, reqPcd, reqUnc} = {1'b1, io, wr, a, sz, wd, page_cache_disable, unc};
        @(negedge sys_clk);
        reqValid = 1'b0;
        // this negedge already lies in the first cycle after the take edge
        lat = 1;
        while (rspValid !== 1'b1 && lat < 20) begin
            @(negedge sys_clk);
            lat++;
        end
    endtask : req
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic io_word_write();
        req(1'b1, 1'b1, 32'h0062, SIZE_WORD, 32'h0000_beef, 1'b0, 1'b0);
        `CHK("latency", 3, lat)
        `CHK("busy ready", 1'b0, reqReady)
        `CHK("port cycles", 1, portCnt)
        `CHK("port addr", 32'h0000_0060, accAddr)
        `CHK("lanes", 4'hc, accByteEn)
        `CHK("data", 16'hbeef, accWdata[31:16])
        `CHK("write flag", 1'b1, accWrite)
        `CHK("cacheable", 1'b0, rspCacheable)
    endtask : io_word_write
    task automatic io_split_wrap();
        req(1'b1, 1'b1, 32'hfffe, SIZE_DWORD, 32'h0403_0201, 1'b0, 1'b0);
        `CHK("latency", 9, lat)
        `CHK("port cycles", 4, portCnt)
        `CHK("lane union", 4'hf, laneOr)
        `CHK("addr union", 32'h0000_fffc, addrOr)
    endtask : io_split_wrap
    task automatic io_reserved_read();
        req(1'b1, 1'b0, 32'h00fa, SIZE_BYTE, 32'h0, 1'b0, 1'b0);
        `CHK("reserved hits", 1, rsvdCnt)
        `CHK("port cycles", 0, portCnt)
        `CHK("read data", 32'h0, rspRdata)
    endtask : io_reserved_read
    task automatic parity_read();
        parityErrIn = 1'b1;
        parityMaskEn = 1'b1;
        req(1'b1, 1'b0, 32'h0100, SIZE_DWORD, 32'h0, 1'b0, 1'b0);
        `CHK("io data", 32'h1122_3344, rspRdata)
        `CHK("io parity", 1'b1, rspParityErr)
        req(1'b0, 1'b0, 32'h1000, SIZE_DWORD, 32'h0, 1'b0, 1'b0);
        `CHK("mem cycles", 1, memCnt)
        `CHK("mem data", 32'h5566_7788, rspRdata)
        `CHK("mem parity", 1'b0, rspParityErr)
        `CHK("mem cacheable", 1'b1, rspCacheable)
        parityErrIn = 1'b0;
    endtask : parity_read
    task automatic cache_block();
        req(1'b0, 1'b0, 32'h1000, SIZE_WORD, 32'h0, 1'b1, 1'b0);
        `CHK("page blocked", 1'b0, rspCacheable)
        req(1'b0, 1'b1, 32'h2000, SIZE_BYTE, 32'h5a, 1'b0, 1'b1);
        `CHK("type blocked", 1'b0, rspCacheable)
        `CHK("port cycles", 0, portCnt)
    endtask : cache_block
    task automatic end_of_test();
        if (errCount == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // reset for two cycles, then every scenario in turn
    initial begin
        {arst_n, reqValid, reqIsIo, reqWrite, reqAddr, reqSize, reqWdata, reqPcd, reqUnc} = '0;
        {parityMaskEn, parityErrIn, errCount, nTests, cycles} = '0;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        io_word_write();
        io_split_wrap();
        io_reserved_read();
        parity_read();
        cache_block();
        end_of_test();
    end
endmodule : iopau_bench
`default_nettype wire
